// [logic/eag_addr_gen.sv]
/*
 * effective-address generator: operand addresses, branch targets, register
 * write-back values, extended immediates and sign-extended load data.
 * assumes the decoder presents one request per cycle with register values already read;
 * every result appears registered on the edge after the request.
 */
// What this block does
// RULE_01 - register direct: operand is the selected register's contents, no address
// RULE_02 - register indirect: address equals the selected register unchanged
// RULE_03 - post-increment: address is old value, register then grows by 1/2/4
// RULE_04 - pre-decrement: register shrinks by 1/2/4 first, that value is address and write-back
// RULE_05 - 4-bit displacement zero-extended, scaled by size, added to selected register
// RULE_06 - indexed: address is selected register plus index register zero
// RULE_07 - 8-bit displacement zero-extended, scaled by size, added to global base
// RULE_08 - indexed global base: global base plus index register zero
// RULE_09 - pc data load: 8-bit displacement zero-extended, times 2 or 4, plus pc
// RULE_10 - longword pc data load clears the two low pc bits before adding
// RULE_11 - short branch: 8-bit displacement sign-extended, doubled, plus pc
// RULE_12 - long branch: 12-bit displacement sign-extended, doubled, plus pc
// RULE_13 - register branch: target is pc plus selected register
// RULE_14 - bit-test and logic immediates are zero-extended to 32 bits
// RULE_15 - move, add and compare-equal immediates are sign-extended to 32 bits
// RULE_16 - software trap immediate zero-extended and multiplied by four
// RULE_17 - multiply-accumulate: destination field is a second source, also post-incremented
// RULE_18 - byte and word load data are sign-extended to longword
// RULE_19 - all sums wrap modulo two to the 32, no overflow flag
// RULE_20 - a competing write to the same register beats the increment write-back
module eag_addr_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // request from the decoder
    input wire logic req_valid_in,
    input wire eag_pkg::eag_mode_e mode_in,
    input wire eag_pkg::eag_size_e size_in,
    input wire logic [11:0] disp_in,
    input wire logic [7:0] imm_in,
    input wire eag_pkg::eag_imm_e imm_kind_in,
    // register values
    input wire logic [3:0] sel_idx_in,
    input wire logic [31:0] selected_general_reg_in,
    input wire logic [3:0] dst_idx_in,
    input wire logic [31:0] dst_reg_in,
    input wire logic [31:0] index_reg_zero_in,
    input wire logic [31:0] global_base_reg_in,
    input wire logic [31:0] pc_in,
    // competing register write in the same instruction
    input wire logic ext_wr_en_in,
    input wire logic [3:0] ext_wr_idx_in,
    // load data from the load/store unit
    input wire logic load_valid_in,
    input wire eag_pkg::eag_size_e load_size_in,
    input wire logic [31:0] load_data_in,
    // addresses, targets, register-direct operand and extended immediate
    output logic addr_valid_out,
    output logic [31:0] addr_out,
    output logic addr2_valid_out,
    output logic [31:0] addr2_out,
    output logic target_valid_out,
    output logic [31:0] target_out,
    output logic operand_valid_out,
    output logic [31:0] operand_out,
    output logic [31:0] imm_ext_out,
    // register write-back
    output logic wb_en_out,
    output logic [3:0] wb_idx_out,
    output logic [31:0] wb_val_out,
    output logic wb2_en_out,
    output logic [3:0] wb2_idx_out,
    output logic [31:0] wb2_val_out,
    // extended load data
    output logic load_ext_valid_out,
    output logic [31:0] load_ext_out
);
    eag_ext_if ext_bus ();

    eag_ext_unit u_ext (
        .ext (ext_bus.unit)
    );

    logic addr_valid_d, addr_valid_q, addr2_valid_d, addr2_valid_q;
    logic [31:0] addr_d, addr_q, addr2_d, addr2_q;
    logic target_valid_d, target_valid_q, operand_valid_d, operand_valid_q;
    logic [31:0] target_d, target_q, operand_d, operand_q, imm_ext_d, imm_ext_q;
    logic wb_en_d, wb_en_q, wb2_en_d, wb2_en_q;
    logic [3:0] wb_idx_d, wb_idx_q, wb2_idx_d, wb2_idx_q;
    logic [31:0] wb_val_d, wb_val_q, wb2_val_d, wb2_val_q;
    logic load_ext_valid_d, load_ext_valid_q;
    logic [31:0] load_ext_d, load_ext_q;
    logic [31:0] step;
    logic [31:0] pc_base;

    // request decode and address arithmetic; plain 32-bit adds wrap by construction
    always_comb
    begin
        ext_bus.mode = mode_in;
        ext_bus.size = size_in;
        ext_bus.disp = disp_in;
        ext_bus.imm = imm_in;
        ext_bus.imm_kind = imm_kind_in;
        step = eag_pkg::size_step(size_in);
        pc_base = pc_in;
        if (size_in != eag_pkg::SZ_BYTE && size_in != eag_pkg::SZ_WORD)
        begin
            pc_base = pc_in & eag_pkg::PC_LONG_MASK; // [RULE_10]
        end
        addr_valid_d = 1'b0;
        addr_d = eag_pkg::WORD_RST;
        addr2_valid_d = 1'b0;
        addr2_d = eag_pkg::WORD_RST;
        target_valid_d = 1'b0;
        target_d = eag_pkg::WORD_RST;
        operand_valid_d = 1'b0;
        operand_d = eag_pkg::WORD_RST;
        wb_en_d = 1'b0;
        wb_idx_d = sel_idx_in;
        wb_val_d = eag_pkg::WORD_RST;
        wb2_en_d = 1'b0;
        wb2_idx_d = dst_idx_in;
        wb2_val_d = eag_pkg::WORD_RST;
        imm_ext_d = ext_bus.imm_ext;
        if (req_valid_in)
        begin
            unique case (mode_in)
                eag_pkg::EA_REG_DIRECT:
                begin
                    operand_valid_d = 1'b1;
                    operand_d = selected_general_reg_in; // [RULE_01]
                end
                eag_pkg::EA_REG_IND:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in; // [RULE_02]
                end
                eag_pkg::EA_POST_INC:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in; // [RULE_03]
                    wb_en_d = 1'b1;
                    wb_val_d = selected_general_reg_in + step; // [RULE_03] [RULE_19]
                end
                eag_pkg::EA_PRE_DEC:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in - step; // [RULE_04] [RULE_19]
                    wb_en_d = 1'b1;
                    wb_val_d = selected_general_reg_in - step; // [RULE_04]
                end
                eag_pkg::EA_REG_DISP:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in + ext_bus.disp_scaled; // [RULE_05]
                end
                eag_pkg::EA_IDX_REG:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in + index_reg_zero_in; // [RULE_06]
                end
                eag_pkg::EA_GBASE_DISP:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = global_base_reg_in + ext_bus.disp_scaled; // [RULE_07]
                end
                eag_pkg::EA_IDX_GBASE:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = global_base_reg_in + index_reg_zero_in; // [RULE_08]
                end
                eag_pkg::EA_PC_DISP:
                begin
                    addr_valid_d = 1'b1;
                    addr_d = pc_base + ext_bus.disp_scaled; // [RULE_09]
                end
                eag_pkg::EA_BR_SHORT, eag_pkg::EA_BR_LONG:
                begin
                    target_valid_d = 1'b1;
                    target_d = pc_in + ext_bus.disp_scaled; // [RULE_11] [RULE_12]
                end
                eag_pkg::EA_PC_REG:
                begin
                    target_valid_d = 1'b1;
                    target_d = pc_in + selected_general_reg_in; // [RULE_13]
                end
                eag_pkg::EA_MAC:
                begin
                    // both operand pointers advance; they are two independent updates
                    addr_valid_d = 1'b1;
                    addr_d = selected_general_reg_in;
                    wb_en_d = 1'b1;
                    wb_val_d = selected_general_reg_in + step;
                    addr2_valid_d = 1'b1;
                    addr2_d = dst_reg_in; // [RULE_17]
                    wb2_en_d = 1'b1;
                    wb2_val_d = dst_reg_in + step; // [RULE_17]
                end
                default: addr_valid_d = 1'b0;
            endcase
            // the loaded or moved value must survive, so the pointer update yields
            if (ext_wr_en_in && ext_wr_idx_in == sel_idx_in)
            begin
                wb_en_d = 1'b0; // [RULE_20]
            end
            if (ext_wr_en_in && ext_wr_idx_in == dst_idx_in)
            begin
                wb2_en_d = 1'b0; // [RULE_20]
            end
        end
    end

    // load data extension
    always_comb
    begin
        load_ext_valid_d = load_valid_in;
        case (load_size_in)
            eag_pkg::SZ_BYTE: load_ext_d = {{24{load_data_in[7]}}, load_data_in[7:0]}; // [RULE_18]
            eag_pkg::SZ_WORD: load_ext_d = {{16{load_data_in[15]}},
                load_data_in[15:0]}; // [RULE_18]
            default: load_ext_d = load_data_in;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            addr_valid_q <= 1'b0;
            addr_q <= eag_pkg::WORD_RST;
            addr2_valid_q <= 1'b0;
            addr2_q <= eag_pkg::WORD_RST;
            target_valid_q <= 1'b0;
            target_q <= eag_pkg::WORD_RST;
            operand_valid_q <= 1'b0;
            operand_q <= eag_pkg::WORD_RST;
            imm_ext_q <= eag_pkg::WORD_RST;
            wb_en_q <= 1'b0;
            wb_idx_q <= eag_pkg::IDX_RST;
            wb_val_q <= eag_pkg::WORD_RST;
            wb2_en_q <= 1'b0;
            wb2_idx_q <= eag_pkg::IDX_RST;
            wb2_val_q <= eag_pkg::WORD_RST;
            load_ext_valid_q <= 1'b0;
            load_ext_q <= eag_pkg::WORD_RST;
        end
        else
        begin
            addr_valid_q <= addr_valid_d;
            addr_q <= addr_d;
            addr2_valid_q <= addr2_valid_d;
            addr2_q <= addr2_d;
            target_valid_q <= target_valid_d;
            target_q <= target_d;
            operand_valid_q <= operand_valid_d;
            operand_q <= operand_d;
            imm_ext_q <= imm_ext_d;
            wb_en_q <= wb_en_d;
            wb_idx_q <= wb_idx_d;
            wb_val_q <= wb_val_d;
            wb2_en_q <= wb2_en_d;
            wb2_idx_q <= wb2_idx_d;
            wb2_val_q <= wb2_val_d;
            load_ext_valid_q <= load_ext_valid_d;
            load_ext_q <= load_ext_d;
        end
    end

    assign addr_valid_out = addr_valid_q;
    assign addr_out = addr_q;
    assign addr2_valid_out = addr2_valid_q;
    assign addr2_out = addr2_q;
    assign target_valid_out = target_valid_q;
    assign target_out = target_q;
    assign operand_valid_out = operand_valid_q;
    assign operand_out = operand_q;
    assign imm_ext_out = imm_ext_q;
    assign wb_en_out = wb_en_q;
    assign wb_idx_out = wb_idx_q;
    assign wb_val_out = wb_val_q;
    assign wb2_en_out = wb2_en_q;
    assign wb2_idx_out = wb2_idx_q;
    assign wb2_val_out = wb2_val_q;
    assign load_ext_valid_out = load_ext_valid_q;
    assign load_ext_out = load_ext_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_req(eag_pkg::eag_mode_e m);
        req_valid_in && mode_in == m;
    endsequence

    sequence s_free_wb;
        !(ext_wr_en_in && ext_wr_idx_in == sel_idx_in);
    endsequence

    a_reg_direct: assert property (s_req(eag_pkg::EA_REG_DIRECT) |=> operand_valid_out // [RULE_01]
        && operand_out == $past(selected_general_reg_in) && !addr_valid_out)
        else $error("register direct operand wrong");
    a_reg_indirect: assert property (s_req(eag_pkg::EA_REG_IND) |=> addr_valid_out // [RULE_02]
        && addr_out == $past(selected_general_reg_in) && !wb_en_out)
        else $error("register indirect address wrong");
    a_post_inc_step: assert property (s_req(eag_pkg::EA_POST_INC) ##0 s_free_wb |=> // [RULE_03]
        addr_out == $past(selected_general_reg_in) && wb_en_out
        && wb_val_out - addr_out == eag_pkg::size_step($past(size_in)))
        else $error("post-increment update wrong");
    a_pre_dec_step: assert property (s_req(eag_pkg::EA_PRE_DEC) ##0 s_free_wb |=> // [RULE_04]
        wb_en_out && addr_out == wb_val_out
        && $past(selected_general_reg_in) - addr_out == eag_pkg::size_step($past(size_in)))
        else $error("pre-decrement update wrong");
    a_index_sum: assert property (s_req(eag_pkg::EA_IDX_REG) |=> // [RULE_06]
        addr_out == $past(selected_general_reg_in) + $past(index_reg_zero_in))
        else $error("indexed address wrong");
    a_gbase_index: assert property (s_req(eag_pkg::EA_IDX_GBASE) |=> // [RULE_08]
        addr_out == $past(global_base_reg_in) + $past(index_reg_zero_in))
        else $error("indexed global base address wrong");
    a_pc_long_align: assert property (s_req(eag_pkg::EA_PC_DISP) // [RULE_10]
        ##0 size_in == eag_pkg::SZ_LONG |=> addr_out[1:0] == 2'h0 && addr_out
        - ($past(pc_in) & eag_pkg::PC_LONG_MASK) == {22'h000000, $past(disp_in[7:0]), 2'h0})
        else $error("longword pc relative address wrong");
    a_short_branch: assert property (s_req(eag_pkg::EA_BR_SHORT) |=> target_valid_out // [RULE_11]
        && target_out == $past(pc_in) + {{23{$past(disp_in[7])}}, $past(disp_in[7:0]), 1'b0})
        else $error("short branch target wrong");
    a_reg_branch: assert property (s_req(eag_pkg::EA_PC_REG) |=> target_valid_out // [RULE_13]
        && target_out == $past(pc_in) + $past(selected_general_reg_in))
        else $error("register branch target wrong");
    a_imm_sign: assert property (req_valid_in && imm_kind_in == eag_pkg::IMM_SIGN |=> // [RULE_15]
        imm_ext_out[31:8] == {24{imm_ext_out[7]}} && imm_ext_out[7:0] == $past(imm_in))
        else $error("signed immediate wrong");
    a_trap_offset: assert property (req_valid_in && imm_kind_in == eag_pkg::IMM_TRAP // [RULE_16]
        |=> imm_ext_out == {22'h000000, $past(imm_in), 2'h0})
        else $error("trap vector offset wrong");
    a_mac_second: assert property (s_req(eag_pkg::EA_MAC) ##0 !ext_wr_en_in |=> // [RULE_17]
        addr2_out == $past(dst_reg_in) && wb2_en_out && wb2_idx_out == $past(dst_idx_in)
        && wb2_val_out - addr2_out == eag_pkg::size_step($past(size_in)))
        else $error("second pointer update wrong");
    a_load_byte: assert property (load_valid_in && load_size_in == eag_pkg::SZ_BYTE // [RULE_18]
        |=> load_ext_valid_out
        && load_ext_out == {{24{$past(load_data_in[7])}}, $past(load_data_in[7:0])})
        else $error("byte load extension wrong");
    a_wb_yields: assert property (req_valid_in && ext_wr_en_in // [RULE_20]
        && ext_wr_idx_in == sel_idx_in |=> !wb_en_out)
        else $error("pointer write-back not suppressed");
endmodule

// [logic/eag_pkg.sv]
/*
 * shared constants, types and helpers of the effective-address generator.
 * assumes a 32-bit core with 16 general registers and byte/word/longword operands.
 */
package eag_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_IDX_W = 4;
    localparam int unsigned DISP_W = 12;
    localparam int unsigned DISP4_W = 4;
    localparam int unsigned DISP8_W = 8;
    localparam int unsigned IMM_W = 8;

    localparam logic [31:0] PC_LONG_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [3:0] IDX_RST = 4'h0;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [1:0] SHIFT_BYTE = 2'h0;
    localparam logic [1:0] SHIFT_WORD = 2'h1;
    localparam logic [1:0] SHIFT_LONG = 2'h2;
    localparam logic [1:0] SHIFT_TRAP = 2'h2;

    typedef enum logic [3:0] {
        EA_REG_DIRECT = 4'h0,
        EA_REG_IND = 4'h1,
        EA_POST_INC = 4'h2,
        EA_PRE_DEC = 4'h3,
        EA_REG_DISP = 4'h4,
        EA_IDX_REG = 4'h5,
        EA_GBASE_DISP = 4'h6,
        EA_IDX_GBASE = 4'h7,
        EA_PC_DISP = 4'h8,
        EA_BR_SHORT = 4'h9,
        EA_BR_LONG = 4'hA,
        EA_PC_REG = 4'hB,
        EA_MAC = 4'hC
    } eag_mode_e;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } eag_size_e;

    typedef enum logic [1:0] {
        IMM_ZERO = 2'h0,
        IMM_SIGN = 2'h1,
        IMM_TRAP = 2'h2
    } eag_imm_e;

    // the unused size code 2'h3 behaves as longword
    function automatic logic [31:0] size_step(input logic [1:0] s);
        case (s)
            SZ_BYTE: size_step = STEP_BYTE;
            SZ_WORD: size_step = STEP_WORD;
            default: size_step = STEP_LONG;
        endcase
    endfunction

    function automatic logic [1:0] size_shift(input logic [1:0] s);
        case (s)
            SZ_BYTE: size_shift = SHIFT_BYTE;
            SZ_WORD: size_shift = SHIFT_WORD;
            default: size_shift = SHIFT_LONG;
        endcase
    endfunction

endpackage

// [logic/eag_ext_if.sv]
/*
 * carrier between the address generator core and its extension unit.
 * assumes both ends sit in the same clock domain; all signals are combinational.
 */
interface eag_ext_if;
    logic [3:0] mode;
    logic [1:0] size;
    logic [11:0] disp;
    logic [7:0] imm;
    logic [1:0] imm_kind;
    logic [31:0] disp_scaled;
    logic [31:0] imm_ext;

    modport core (
        output mode,
        output size,
        output disp,
        output imm,
        output imm_kind,
        input disp_scaled,
        input imm_ext
    );

    modport unit (
        input mode,
        input size,
        input disp,
        input imm,
        input imm_kind,
        output disp_scaled,
        output imm_ext
    );
endinterface

// [logic/eag_ext_unit.sv]
/*
 * displacement extension and scaling, and immediate extension.
 * assumes the decoder places every displacement right-aligned in the 12-bit field.
 */
module eag_ext_unit (
    eag_ext_if.unit ext
);
    logic [11:0] d;

    always_comb
    begin
        d = ext.disp;
        case (ext.mode)
            eag_pkg::EA_REG_DISP:
            begin
                ext.disp_scaled = {28'h0000000, d[3:0]}
                    << eag_pkg::size_shift(ext.size); // [RULE_05]
            end
            eag_pkg::EA_GBASE_DISP:
            begin
                ext.disp_scaled = {24'h000000, d[7:0]}
                    << eag_pkg::size_shift(ext.size); // [RULE_07]
            end
            eag_pkg::EA_PC_DISP:
            begin
                // no byte form exists here, so byte scales as word
                if (ext.size == eag_pkg::SZ_BYTE || ext.size == eag_pkg::SZ_WORD)
                begin
                    ext.disp_scaled = {23'h000000, d[7:0], 1'b0}; // [RULE_09]
                end
                else
                begin
                    ext.disp_scaled = {22'h000000, d[7:0], 2'h0}; // [RULE_09]
                end
            end
            eag_pkg::EA_BR_SHORT:
            begin
                ext.disp_scaled = {{23{d[7]}}, d[7:0], 1'b0}; // [RULE_11]
            end
            eag_pkg::EA_BR_LONG:
            begin
                ext.disp_scaled = {{19{d[11]}}, d[11:0], 1'b0}; // [RULE_12]
            end
            default:
            begin
                ext.disp_scaled = eag_pkg::WORD_RST;
            end
        endcase
        case (ext.imm_kind)
            eag_pkg::IMM_SIGN: ext.imm_ext = {{24{ext.imm[7]}}, ext.imm}; // [RULE_15]
            eag_pkg::IMM_TRAP: ext.imm_ext = {22'h000000, ext.imm, 2'h0}; // [RULE_16]
            default: ext.imm_ext = {24'h000000, ext.imm}; // [RULE_14]
        endcase
    end
endmodule

// [verification/eag_regfile_model.sv]
/*
 * register file model that stands beside the address generator: sixteen
 * general registers read by index and updated from both write-back ports.
 * assumes write-backs arrive one cycle after the request that caused them.
 */
module eag_regfile_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // write-back ports
    input wire logic wb_en_in,
    input wire logic [3:0] wb_idx_in,
    input wire logic [31:0] wb_val_in,
    input wire logic wb2_en_in,
    input wire logic [3:0] wb2_idx_in,
    input wire logic [31:0] wb2_val_in,
    // read ports
    input wire logic [3:0] sel_idx_in,
    input wire logic [3:0] dst_idx_in,
    output logic [31:0] sel_val_out,
    output logic [31:0] dst_val_out,
    output logic [31:0] idx_zero_val_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs_q [16];
    // values near the top of the range so that small steps wrap
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < 16; i++)
                regs_q[i] <= 32'hFFFF_FFF0 | 32'(i);
        end
        else
        begin
            if (wb_en_in)
                regs_q[wb_idx_in] <= wb_val_in;
            if (wb2_en_in)
                regs_q[wb2_idx_in] <= wb2_val_in;
        end
    end
    assign sel_val_out = regs_q[sel_idx_in];
    assign dst_val_out = regs_q[dst_idx_in];
    assign idx_zero_val_out = regs_q[0];
endmodule

// [verification/eag_addr_gen_bench.sv]
/*
 * self-checking bench of the address generator with a register file model.
 * assumes every result shows just after the edge that takes the request.
 */
module eag_addr_gen_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    eag_pkg::eag_mode_e mode_in = eag_pkg::EA_REG_DIRECT;
    eag_pkg::eag_size_e size_in = eag_pkg::SZ_BYTE;
    eag_pkg::eag_size_e load_size_in = eag_pkg::SZ_BYTE;
    eag_pkg::eag_imm_e imm_kind_in = eag_pkg::IMM_ZERO;
    logic [11:0] disp_in = 12'h000;
    logic [7:0] imm_in = 8'h00;
    logic [3:0] sel_idx_in = 4'h0, dst_idx_in = 4'h0, ext_wr_idx_in = 4'h0;
    logic ext_wr_en_in = 1'b0, load_valid_in = 1'b0;
    logic [31:0] global_base_reg_in = 32'h0, pc_in = 32'h0, load_data_in = 32'h0;
    logic [31:0] selected_general_reg_in, dst_reg_in, index_reg_zero_in;
    logic addr_valid_out, addr2_valid_out, target_valid_out, operand_valid_out;
    logic wb_en_out, wb2_en_out, load_ext_valid_out;
    logic [3:0] wb_idx_out, wb2_idx_out;
    logic [31:0] addr_out, addr2_out, target_out, operand_out, imm_ext_out;
    logic [31:0] wb_val_out, wb2_val_out, load_ext_out;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] mir [16];

    eag_addr_gen eag_addr_gen_inst (.*);
    eag_regfile_model eag_regfile_model_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .wb_en_in(wb_en_out), .wb_idx_in(wb_idx_out), .wb_val_in(wb_val_out),
        .wb2_en_in(wb2_en_out), .wb2_idx_in(wb2_idx_out), .wb2_val_in(wb2_val_out),
        .sel_idx_in(sel_idx_in), .dst_idx_in(dst_idx_in), .sel_val_out(selected_general_reg_in),
        .dst_val_out(dst_reg_in), .idx_zero_val_out(index_reg_zero_in));

    always #10 clk_in = ~clk_in;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one request, then back to the cycle where its answer stands
    task automatic go(input logic [3:0] m, input logic [1:0] s, input logic [11:0] d);
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b1;
        mode_in = eag_pkg::eag_mode_e'(m);
        size_in = eag_pkg::eag_size_e'(s);
        disp_in = d;
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b0;
    endtask

    task automatic t_incdec();
        logic [31:0] st;
        for (int s = 0; s < 3; s++)
        begin
            st = 32'h1 << s;
            sel_idx_in = 4'hE;
            go(4'h2, s[1:0], 12'h000);
            chk("post_addr", addr_out, mir[14]);
            chk("post_wb", wb_val_out, mir[14] + st);
            chk("post_idx", wb_idx_out, 32'hE);
            chk("post_en", wb_en_out, 32'h1);
            mir[14] = mir[14] + st;
            sel_idx_in = 4'h3;
            go(4'h3, s[1:0], 12'h000);
            chk("pre_addr", addr_out, mir[3] - st);
            chk("pre_wb", wb_val_out, mir[3] - st);
            mir[3] = mir[3] - st;
        end
        go(4'h0, 2'h2, 12'h000);
        chk("operand", operand_out, mir[3]);
        chk("op_valid", operand_valid_out, 32'h1);
        chk("no_addr", addr_valid_out, 32'h0);
        go(4'h1, 2'h2, 12'h000);
        chk("ind_addr", addr_out, mir[3]);
        ext_wr_en_in = 1'b1;
        ext_wr_idx_in = 4'h3;
        go(4'h2, 2'h2, 12'h000);
        ext_wr_en_in = 1'b0;
        chk("clash_wb", wb_en_out, 32'h0);
        chk("clash_addr", addr_out, mir[3]);
    endtask

    task automatic t_disp();
        global_base_reg_in = 32'h8000_0000;
        sel_idx_in = 4'h5;
        for (int s = 0; s < 3; s++)
        begin
            go(4'h4, s[1:0], 12'h00F);
            chk("disp4", addr_out, mir[5] + (32'hF << s));
            go(4'h6, s[1:0], 12'h0FF);
            chk("gbase_disp", addr_out, 32'h8000_0000 + (32'hFF << s));
        end
        go(4'h5, 2'h2, 12'h000);
        chk("idx", addr_out, mir[5] + mir[0]);
        go(4'h7, 2'h2, 12'h000);
        chk("idx_gbase", addr_out, 32'h8000_0000 + mir[0]);
    endtask

    task automatic t_pc();
        pc_in = 32'h0000_1003;
        sel_idx_in = 4'h2;
        go(4'h8, 2'h1, 12'h0FF);
        chk("pc_word", addr_out, 32'h0000_1201);
        go(4'h8, 2'h2, 12'h0FF);
        chk("pc_long", addr_out, 32'h0000_13FC);
        go(4'h9, 2'h2, 12'h080);
        chk("br_short", target_out, 32'h0000_0F03);
        chk("br_valid", target_valid_out, 32'h1);
        go(4'hA, 2'h2, 12'h800);
        chk("br_long", target_out, 32'h0000_0003);
        go(4'hB, 2'h2, 12'h000);
        chk("br_reg", target_out, 32'h0000_1003 + mir[2]);
    endtask

    task automatic t_imm_mac_load();
        logic [31:0] ie [3] = '{32'h0000_009C, 32'hFFFF_FF9C, 32'h0000_0270};
        logic [31:0] le [3] = '{32'hFFFF_FF80, 32'hFFFF_8680, 32'h1234_8680};
        imm_in = 8'h9C;
        for (int k = 0; k < 3; k++)
        begin
            imm_kind_in = eag_pkg::eag_imm_e'(k);
            go(4'h0, 2'h2, 12'h000);
            chk("imm_ext", imm_ext_out, ie[k]);
        end
        sel_idx_in = 4'h4;
        dst_idx_in = 4'h6;
        go(4'hC, 2'h1, 12'h000);
        chk("mac_addr", addr_out, mir[4]);
        chk("mac_addr2", addr2_out, mir[6]);
        chk("mac_wb", wb_val_out, mir[4] + 32'h2);
        chk("mac_wb2", wb2_val_out, mir[6] + 32'h2);
        chk("mac_idx2", wb2_idx_out, 32'h6);
        chk("mac_valid2", addr2_valid_out, 32'h1);
        chk("mac_wb2_en", wb2_en_out, 32'h1);
        load_data_in = 32'h1234_8680;
        for (int s = 0; s < 3; s++)
        begin
            @(posedge clk_in);
            #1;
            load_valid_in = 1'b1;
            load_size_in = eag_pkg::eag_size_e'(s);
            @(posedge clk_in);
            #1;
            load_valid_in = 1'b0;
            chk("load_ext", load_ext_out, le[s]);
            chk("load_valid", load_ext_valid_out, 32'h1);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        for (int i = 0; i < 16; i++)
            mir[i] = 32'hFFFF_FFF0 | 32'(i);
        repeat (5) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        chk("rst_addr_valid", addr_valid_out, 32'h0);
        t_incdec();
        t_disp();
        t_pc();
        t_imm_mac_load();
        chk("rf_post", eag_regfile_model_inst.regs_q[14], mir[14]);
        results();
    end

    // cuts a hang short; far beyond the some 63 cycles the run needs
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
endmodule
